// ===== common/ctc_pkg.sv
package ctc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_UPPER_CMP = 8'h04;
   localparam logic [7:0] OFS_LOWER_CMP = 8'h08;
   localparam logic [7:0] OFS_LOWER_HCMP = 8'h0C;
   localparam logic [7:0] OFS_CARRIER = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int CTRL_LOWER_RUN = 0;
   localparam int CTRL_UPPER_RUN = 1;
   localparam int CTRL_LOWER_OE = 2;
   localparam int CTRL_UPPER_OE = 3;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_LOWER_CS_LSB = 8;
   localparam int CTRL_UPPER_CS_LSB = 12;

   // Carrier output control fields
   localparam int CARR_REMOTE = 2;
   localparam int CARR_BUF = 1;
   localparam int CARR_ACT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and counter geometry
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0] CMP_RST = 8'h00;
   localparam int CNT_W = 8;
   localparam logic [7:0] CNT_MAX = 8'hFF;

   // Main clock prescaler for the divide-by-4 source
   localparam logic [1:0] MAIN_DIV4_LAST = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Count clock select codes
   localparam logic [2:0] CS_MAIN = 3'h0;
   localparam logic [2:0] CS_MAIN_DIV4 = 3'h1;
   localparam logic [2:0] CS_EXT = 3'h2;
   localparam logic [2:0] CS_EXT_DIV2 = 3'h3;
   localparam logic [2:0] CS_EXT_DIV4 = 3'h4;
   localparam logic [2:0] CS_EXT_DIV8 = 3'h5;

   typedef enum logic [1:0] {
      MODE_8BIT,
      MODE_CASCADE,
      MODE_CARRIER,
      MODE_PWM
   } mode_e;

endpackage

// ===== hdl/ctc_counter.sv
`timescale 1ns/1ns
module ctc_counter
#(
   parameter int WIDTH = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic inc,
   output logic [WIDTH-1:0] count
);

   logic [WIDTH-1:0] count_reg;

   // Clear wins over increment; wraps naturally at full scale
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_reg <= '0;
      else if (clr)
         count_reg <= '0;
      else if (inc)
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   assign count = count_reg;

endmodule // ctc_counter

// ===== hdl/ctc_clock_sel.sv
`timescale 1ns/1ns
module ctc_clock_sel
   import ctc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic ext_pin,
   output logic tick
);

   logic ext_prev_reg;
   logic [1:0] main_div_reg;
   logic [2:0] ext_div_reg;
   logic ext_edge;

   assign ext_edge = ext_pin & ~ext_prev_reg;

   // Dividers restart while halted, so each run starts from a fresh phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_prev_reg <= 1'b0;
         main_div_reg <= 2'h0;
         ext_div_reg <= 3'h0;
      end
      else
      begin
         ext_prev_reg <= ext_pin;
         if (!run)
         begin
            main_div_reg <= 2'h0;
            ext_div_reg <= 3'h0;
         end
         else
         begin
            main_div_reg <= main_div_reg + 2'h1;
            if (ext_edge)
               ext_div_reg <= ext_div_reg + 3'h1;
         end
      end
   end

   always_comb
   begin
      tick = 1'b0;
      if (run)
      begin
         case (sel)
            CS_MAIN: tick = 1'b1;
            CS_MAIN_DIV4: tick = (main_div_reg == MAIN_DIV4_LAST);
            CS_EXT: tick = ext_edge;
            CS_EXT_DIV2: tick = ext_edge & ext_div_reg[0];
            CS_EXT_DIV4: tick = ext_edge & (&ext_div_reg[1:0]);
            CS_EXT_DIV8: tick = ext_edge & (&ext_div_reg);
            default: tick = 1'b0;
         endcase
      end
   end

   property p_div4_spacing;
      @(posedge pclk) disable iff (!presetn)
      (run && sel == CS_MAIN_DIV4 && tick) |=> !tick [*3];
   endproperty
   a_div4_spacing: assert property (p_div4_spacing)
      else $error("main clock divided by 4 ticked too early");

endmodule // ctc_clock_sel

// ===== hdl/cascaded_timer_carrier_pwm.sv
`timescale 1ns/1ns
// Overview of operation
// - Cascade: upper counter is high byte, lower counter low byte.
// - Cascade start and clear follow only the lower run enable.
// - Cascade double match clears both, raises lower interrupt only.
// - Clock select: main, main/4, pin, pin/2, pin/4, pin/8.
// - Cascade event counting adds one per valid external pin edge.
// - Cascade square wave toggles lower pin on each double match.
// - Lower run cleared in cascade forces square-wave output low.
// - Lower pin starts low when its output becomes enabled, unless carrier mode with remote select set drives the active gate.
// - Carrier: match toggles output, raises interrupt, swaps compare.
// - Carrier: upper interrupt rise copies buffer gate into active gate.
// - Carrier reaches lower pin only with active gate set and carrier select.
// - Carrier control: bit 2 remote select, bit 1 buffer, bit 0 active.
// - Output enabled: active gate writes ignored, except during upper irq.
// - Buffer gate is lost when carrier stops; software reloads it.
// - PWM: overflow sets upper pin, match clears it, no counter clear.
module cascaded_timer_carrier_pwm
   import ctc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_count_pin,
   output logic upper_timer_pin,
   output logic lower_timer_pin,
   output logic upper_match_interrupt,
   output logic lower_match_interrupt
);

   logic [15:0] ctrl_reg;
   logic [7:0] upper_compare_reg;
   logic [7:0] lower_compare_reg;
   logic [7:0] lower_high_width_compare_reg;
   logic remote_output_select_reg;
   logic carrier_gate_buffer_reg;
   logic carrier_gate_active_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic lower_pin_reg;
   logic lower_lvl_reg;
   logic upper_lvl_reg;
   logic upper_irq_reg;
   logic lower_irq_reg;
   logic phase_high_reg;
   logic lower_run_prev_reg;
   logic [15:0] gap_reg;
   logic gap_ok_reg;
   logic lower_pin_next;
   mode_e mode;
   logic casc, carrier, pwm;
   logic l_run, u_run, l_oe, u_oe;
   logic l_tick, u_tick_sel, u_tick;
   logic [7:0] lcount, ucount, l_cmp_val;
   logic l_match, u_match, casc_match;
   logic l_evt, u_evt, u_set, u_irq_rise, u_ovf;
   logic l_clr, l_inc, u_clr, u_inc;
   logic wr_en, wr_carr, c_stop;

   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == OFS_CTRL) || (a == OFS_UPPER_CMP) ||
                   (a == OFS_LOWER_CMP) || (a == OFS_LOWER_HCMP) ||
                   (a == OFS_CARRIER) || (a == OFS_STATUS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode and count clocks
   assign mode = mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
   assign casc = (mode == MODE_CASCADE);
   assign carrier = (mode == MODE_CARRIER);
   assign pwm = (mode == MODE_PWM);
   assign l_run = ctrl_reg[CTRL_LOWER_RUN];
   assign u_run = casc ? l_run : ctrl_reg[CTRL_UPPER_RUN];
   assign l_oe = ctrl_reg[CTRL_LOWER_OE];
   assign u_oe = ctrl_reg[CTRL_UPPER_OE];

   ctc_clock_sel u_lower_clk (
      .pclk(pclk),
      .presetn(presetn),
      .run(l_run),
      .sel(ctrl_reg[CTRL_LOWER_CS_LSB +: 3]),
      .ext_pin(external_count_pin),
      .tick(l_tick)
   );

   ctc_clock_sel u_upper_clk (
      .pclk(pclk),
      .presetn(presetn),
      .run(u_run),
      .sel(ctrl_reg[CTRL_UPPER_CS_LSB +: 3]),
      .ext_pin(external_count_pin),
      .tick(u_tick_sel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Counters and compare events
   assign l_cmp_val = (carrier && phase_high_reg) ?
                      lower_high_width_compare_reg : lower_compare_reg;
   assign l_match = (lcount == l_cmp_val);
   assign u_match = (ucount == upper_compare_reg);
   assign casc_match = l_match & u_match;
   assign l_evt = l_tick & (casc ? casc_match : l_match);
   assign l_clr = ~l_run | l_evt;
   assign l_inc = l_tick & ~l_evt;
   // Carry from the low byte drives the high byte in cascade
   assign u_tick = casc ? (l_tick & (lcount == CNT_MAX) & ~casc_match)
                        : u_tick_sel;
   assign u_evt = ~casc & ~pwm & u_tick & u_match;
   assign u_set = u_evt | (pwm & u_tick & u_match);
   assign u_ovf = pwm & u_tick & (ucount == CNT_MAX);
   assign u_clr = ~u_run | (casc ? l_evt : u_evt);
   assign u_inc = u_tick & ~u_evt;
   assign u_irq_rise = u_set & ~upper_irq_reg;

   ctc_counter #(.WIDTH(CNT_W)) u_lower_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(l_clr),
      .inc(l_inc),
      .count(lcount)
   );

   ctc_counter #(.WIDTH(CNT_W)) u_upper_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(u_clr),
      .inc(u_inc),
      .count(ucount)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt requests; upper one stays high until its next count tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lower_irq_reg <= 1'b0;
         upper_irq_reg <= 1'b0;
      end
      else
      begin
         lower_irq_reg <= l_evt;
         if (!u_run)
            upper_irq_reg <= 1'b0;
         else if (u_set)
            upper_irq_reg <= 1'b1;
         else if (u_tick_sel)
            upper_irq_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output levels
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lower_lvl_reg <= 1'b0;
         phase_high_reg <= 1'b0;
      end
      else
      begin
         if (!l_oe || !l_run)
            lower_lvl_reg <= 1'b0;
         else if (l_evt)
            lower_lvl_reg <= ~lower_lvl_reg;
         if (!carrier || !l_run)
            phase_high_reg <= 1'b0;
         else if (l_evt)
            phase_high_reg <= ~phase_high_reg;
      end
   end

   always_comb
   begin
      lower_pin_next = 1'b0;
      if (l_oe && carrier && remote_output_select_reg)
         lower_pin_next = carrier_gate_active_reg;
      else if (l_oe && carrier)
         lower_pin_next = carrier_gate_active_reg & lower_lvl_reg;
      else if (l_oe)
         lower_pin_next = lower_lvl_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lower_pin_reg <= 1'b0;
         upper_lvl_reg <= 1'b0;
      end
      else
      begin
         lower_pin_reg <= lower_pin_next;
         // Upper pin is not usable while cascaded
         if (!u_oe || !u_run || casc)
            upper_lvl_reg <= 1'b0;
         else if (u_ovf)
            upper_lvl_reg <= 1'b1;
         else if (pwm && u_set)
            upper_lvl_reg <= 1'b0;
         else if (u_evt)
            upper_lvl_reg <= ~upper_lvl_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Carrier gating bits
   assign wr_carr = wr_en && (paddr == OFS_CARRIER);
   assign c_stop = carrier && lower_run_prev_reg && !l_run;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         remote_output_select_reg <= 1'b0;
         carrier_gate_buffer_reg <= 1'b0;
         carrier_gate_active_reg <= 1'b0;
         lower_run_prev_reg <= 1'b0;
      end
      else
      begin
         lower_run_prev_reg <= l_run;
         if (c_stop)
         begin
            carrier_gate_buffer_reg <= 1'b0;
            carrier_gate_active_reg <= 1'b0;
         end
         if (carrier && u_irq_rise)
            carrier_gate_active_reg <= carrier_gate_buffer_reg;
         if (wr_carr)
         begin
            remote_output_select_reg <= pwdata[CARR_REMOTE];
            carrier_gate_buffer_reg <= pwdata[CARR_BUF];
            if (!l_oe)
               carrier_gate_active_reg <= pwdata[CARR_ACT];
            else if (upper_irq_reg)
               carrier_gate_active_reg <= pwdata[CARR_BUF];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle
   assign wr_en = psel && penable && pwrite && pready_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         pready_reg <= psel && !penable;
         pslverr_reg <= psel && !penable && !known_addr(paddr);
         if (psel && !penable && !pwrite)
         begin
            if (paddr == OFS_CTRL)
               prdata_reg <= {16'h0000, ctrl_reg};
            else if (paddr == OFS_UPPER_CMP)
               prdata_reg <= {24'h000000, upper_compare_reg};
            else if (paddr == OFS_LOWER_CMP)
               prdata_reg <= {24'h000000, lower_compare_reg};
            else if (paddr == OFS_LOWER_HCMP)
               prdata_reg <= {24'h000000, lower_high_width_compare_reg};
            else if (paddr == OFS_CARRIER)
               prdata_reg <= {29'h00000000, remote_output_select_reg,
                  carrier_gate_buffer_reg, carrier_gate_active_reg};
            else if (paddr == OFS_STATUS)
               prdata_reg <= {12'h000, upper_irq_reg, lower_irq_reg,
                  upper_lvl_reg, lower_pin_reg, ucount, lcount};
            else
               prdata_reg <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= CTRL_RST;
         upper_compare_reg <= CMP_RST;
         lower_compare_reg <= CMP_RST;
         lower_high_width_compare_reg <= CMP_RST;
      end
      else if (wr_en)
      begin
         if (paddr == OFS_CTRL)
            ctrl_reg <= pwdata[15:0];
         else if (paddr == OFS_UPPER_CMP)
            upper_compare_reg <= pwdata[7:0];
         else if (paddr == OFS_LOWER_CMP)
            lower_compare_reg <= pwdata[7:0];
         else if (paddr == OFS_LOWER_HCMP)
            lower_high_width_compare_reg <= pwdata[7:0];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign lower_timer_pin = lower_pin_reg;
   assign upper_timer_pin = upper_lvl_reg;
   assign upper_match_interrupt = upper_irq_reg;
   assign lower_match_interrupt = lower_irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks; gap counter measures ticks between cascade matches
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_reg <= 16'h0000;
         gap_ok_reg <= 1'b0;
      end
      else
      begin
         if (l_evt || !l_run)
            gap_reg <= 16'h0000;
         else if (l_tick)
            gap_reg <= gap_reg + 16'h0001;
         if (wr_en || !casc || !l_run)
            gap_ok_reg <= 1'b0;
         else if (l_evt)
            gap_ok_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_casc_match;
      casc && l_run && l_evt;
   endsequence
   sequence s_both_clear;
      lcount == 8'h00 && ucount == 8'h00;
   endsequence

   property p_carry;
      (casc && l_run && l_tick && lcount == CNT_MAX && !casc_match)
      |=> ucount == $past(ucount) + 8'h01;
   endproperty
   a_carry: assert property (p_carry)
      else $error("cascade carry did not advance upper count");

   property p_casc_halt;
      (casc && !l_run) |=> s_both_clear;
   endproperty
   a_casc_halt: assert property (p_casc_halt)
      else $error("cascade counters not held clear while stopped");

   property p_casc_match;
      s_casc_match |=> s_both_clear and (lower_irq_reg && !upper_irq_reg);
   endproperty
   a_casc_match: assert property (p_casc_match)
      else $error("cascade match did not clear both or raised wrong irq");

   property p_period;
      (s_casc_match and gap_ok_reg)
      |-> gap_reg == {upper_compare_reg, lower_compare_reg};
   endproperty
   a_period: assert property (p_period)
      else $error("cascade interval length wrong");

   property p_square;
      (s_casc_match and l_oe) |=> lower_lvl_reg != $past(lower_lvl_reg);
   endproperty
   a_square: assert property (p_square)
      else $error("square wave did not toggle on match");

   property p_square_off;
      (casc && !l_run) |=> ##1 !lower_timer_pin;
   endproperty
   a_square_off: assert property (p_square_off)
      else $error("square wave not forced low when stopped");

   property p_oe_low;
      ($rose(l_oe) && !carrier) |=> !lower_timer_pin;
   endproperty
   a_oe_low: assert property (p_oe_low)
      else $error("lower pin not low when output enabled");

   property p_carrier_swap;
      (carrier && l_run && l_evt)
      |=> phase_high_reg != $past(phase_high_reg) && lower_irq_reg;
   endproperty
   a_carrier_swap: assert property (p_carrier_swap)
      else $error("carrier match did not swap compare or raise irq");

   property p_reload;
      (carrier && u_irq_rise && !wr_carr && !c_stop)
      |=> carrier_gate_active_reg == $past(carrier_gate_buffer_reg);
   endproperty
   a_reload: assert property (p_reload)
      else $error("active gate not reloaded on upper irq rise");

   property p_gate_closed;
      (carrier && !carrier_gate_active_reg) |=> !lower_timer_pin;
   endproperty
   a_gate_closed: assert property (p_gate_closed)
      else $error("carrier leaked while gate closed");

   property p_nrz_protect;
      (wr_carr && l_oe && !upper_irq_reg && !u_irq_rise && !c_stop)
      |=> carrier_gate_active_reg == $past(carrier_gate_active_reg);
   endproperty
   a_nrz_protect: assert property (p_nrz_protect)
      else $error("active gate written while output enabled");

   property p_pwm_ovf;
      (u_ovf && u_oe && u_run) |=> upper_timer_pin;
   endproperty
   a_pwm_ovf: assert property (p_pwm_ovf)
      else $error("pwm output not high after overflow");

endmodule // cascaded_timer_carrier_pwm

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
   import ctc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, ext_pin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, upper_pin, lower_pin, upper_irq, lower_irq, er;
   logic up_seen;
   int num_errors = 0;
   int comparisons = 0;
   int a, b;

   cascaded_timer_carrier_pwm cascaded_timer_carrier_pwm_inst
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_count_pin(ext_pin),
      .upper_timer_pin(upper_pin), .lower_timer_pin(lower_pin),
      .upper_match_interrupt(upper_irq), .lower_match_interrupt(lower_irq)
   );

   initial
   begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request holds until pready is seen high at a rising edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1 && n < 50);
      if (n >= 50)
      begin
         num_errors++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return lower_irq;
         1: return lower_pin;
         2: return upper_pin;
         default: return upper_irq;
      endcase
   endfunction

   // Cycles until the chosen output reaches v, bounded
   task wait_lvl(input int s, input logic v, output int c);
      c = 0;
      do
      begin
         @(negedge pclk);
         c++;
         if (upper_irq === 1)
            up_seen = 1;
      end
      while (pick(s) !== v && c < 3000);
      if (c >= 3000)
      begin
         num_errors++;
         finish_test();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task t_apb();
      apb(1, OFS_UPPER_CMP, 32'h0000_00A5);
      apb(0, OFS_UPPER_CMP, 0);
      check(rd, 32'h0000_00A5);
      apb(0, 8'h18, 0);
      check(rd, 32'h0000_0000);
      check({31'h0, er}, 32'h0000_0001);
      $display("test apb done");
   endtask

   task t_interval(input logic [2:0] cs, input logic [7:0] u,
                   input logic [7:0] l);
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_UPPER_CMP, {24'h0, u});
      apb(1, OFS_LOWER_CMP, {24'h0, l});
      // Upper run bit left low: cascade must ignore it
      apb(1, OFS_CTRL, {21'h0, cs, 8'h11});
      up_seen = 0;
      wait_lvl(0, 1, a);
      wait_lvl(0, 0, a);
      wait_lvl(0, 1, b);
      check(a + b, (256 * u + l + 1) * (cs == CS_MAIN ? 1 : 4));
      check(up_seen, 0);
      $display("test interval cs=%0d done", cs);
   endtask

   task t_square();
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_UPPER_CMP, 0);
      apb(1, OFS_LOWER_CMP, 4);
      apb(1, OFS_CTRL, 32'h0000_0015);
      repeat (2) @(negedge pclk);
      check(lower_pin, 0);
      wait_lvl(1, 1, a);
      wait_lvl(1, 0, a);
      check(a, 5);
      // Stop lands just before the next toggle would raise the pin
      apb(1, OFS_CTRL, 32'h0000_0014);
      repeat (8) @(negedge pclk);
      check(lower_pin, 0);
      $display("test square done");
   endtask

   task t_event();
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_UPPER_CMP, 32'hFF);
      apb(1, OFS_LOWER_CMP, 32'hFF);
      apb(1, OFS_CTRL, 32'h0000_0211);
      repeat (5)
      begin
         @(posedge pclk);
         ext_pin <= 1;
         repeat (2) @(posedge pclk);
         ext_pin <= 0;
         @(posedge pclk);
      end
      apb(0, OFS_STATUS, 0);
      check(rd[15:0], 16'h0005);
      $display("test event done");
   endtask

   task t_carrier();
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_LOWER_CMP, 1);
      apb(1, OFS_LOWER_HCMP, 2);
      apb(1, OFS_UPPER_CMP, 7);
      apb(1, OFS_CARRIER, 32'h0000_0002);
      apb(1, OFS_CTRL, 32'h0000_0027);
      // Upper match needs 8 ticks; gate stays closed until then
      wait_lvl(1, 1, a);
      check(a >= 8, 1);
      apb(0, OFS_CARRIER, 0);
      check(rd[0], 1);
      // High width uses the high compare, low width the low compare
      wait_lvl(1, 1, a);
      wait_lvl(1, 0, a);
      wait_lvl(1, 1, b);
      check({16'h0000, a[7:0], b[7:0]}, 32'h0000_0302);
      wait_lvl(3, 0, a);
      apb(1, OFS_CARRIER, 0);
      apb(0, OFS_CARRIER, 0);
      check(rd[0], 1);
      apb(0, OFS_CARRIER, 0);
      check(rd, 32'h0000_0000);
      $display("test carrier done");
   endtask

   task t_pwm();
      apb(1, OFS_CTRL, 0);
      apb(1, OFS_UPPER_CMP, 32'h80);
      apb(1, OFS_CTRL, 32'h0000_003A);
      wait_lvl(2, 1, a);
      wait_lvl(2, 0, a);
      check(upper_irq, 1);
      wait_lvl(2, 1, b);
      check({a[15:0], b[15:0]}, {16'd129, 16'd127});
      $display("test pwm done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      ext_pin = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      t_apb();
      t_interval(CS_MAIN, 8'h01, 8'h02);
      t_interval(CS_MAIN_DIV4, 8'h00, 8'h02);
      t_square();
      t_event();
      t_carrier();
      t_pwm();
      finish_test();
   end

endmodule // tb_top
